// ==== rtl/sbs_map.vh ====
// Purpose: Constants for the sensorless startup sequencer.
// Assumes: Plain Verilog-2005 include by bare name.
// Notes:   Definitions only.
`ifndef SBS_MAP_VH
`define SBS_MAP_VH
`define SBS_MODE_ALIGN 2'h0
`define SBS_MODE_RAMP  2'h1
`define SBS_MODE_RUN   2'h2
`define SBS_ST_R 3'h0
`define SBS_ST_A 3'h1
`define SBS_ST_B 3'h2
`define SBS_ST_C 3'h3
`define SBS_ST_D 3'h4
`define SBS_ST_E 3'h5
`define SBS_ST_F 3'h6
`define SBS_SEL_NONE 2'h0
`define SBS_SEL_A    2'h1
`define SBS_SEL_B    2'h2
`define SBS_SEL_C    2'h3
`define SBS_SYNC_W   2
`endif

// ==== rtl/sbs_phase_table.v ====
// Purpose: Decode of a commutation state into bridge drives and sampler select.
// Assumes: State codes from sbs_map.vh; outputs are registered.
// Notes:   Low drives active high, high drives active low.
`timescale 1ns/1ps
`include "sbs_map.vh"
module sbs_phase_table (
  input  wire       core_clk, // System clock.
  input  wire       sys_rst,  // Asynchronous reset, active high.
  input  wire       clk_en,   // Freezes state while low.
  input  wire [2:0] state,    // Commutation state code.
  output reg  [2:0] low_drv,  // Low drives c,b,a, active high.
  output reg  [2:0] high_n,   // High drives c,b,a, active low.
  output reg  [1:0] sel       // Sampled phase select.
);
  reg [2:0] lo_next;
  reg [2:0] hi_next;
  reg [1:0] sel_next;

  // Table of on-switches per state; bit0 is phase a.
  always @* begin
    lo_next  = 3'b010;
    hi_next  = 3'b101;
    sel_next = `SBS_SEL_NONE;
    case (state)
      `SBS_ST_A: begin lo_next = 3'b100; hi_next = 3'b001;
        sel_next = `SBS_SEL_B; end
      `SBS_ST_B: begin lo_next = 3'b100; hi_next = 3'b010;
        sel_next = `SBS_SEL_A; end
      `SBS_ST_C: begin lo_next = 3'b001; hi_next = 3'b010;
        sel_next = `SBS_SEL_C; end
      `SBS_ST_D: begin lo_next = 3'b001; hi_next = 3'b100;
        sel_next = `SBS_SEL_B; end
      `SBS_ST_E: begin lo_next = 3'b010; hi_next = 3'b100;
        sel_next = `SBS_SEL_A; end
      `SBS_ST_F: begin lo_next = 3'b010; hi_next = 3'b001;
        sel_next = `SBS_SEL_C; end
      default: begin lo_next = 3'b010; hi_next = 3'b101;
        sel_next = `SBS_SEL_NONE; end
    endcase
  end

  // Register outputs; reset shows the align pattern at once.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_drv <= 3'b010;
      high_n  <= 3'b010;
      sel     <= `SBS_SEL_NONE;
    end else if (clk_en) begin
      low_drv <= lo_next;
      high_n  <= ~hi_next;
      sel     <= sel_next;
    end
  end
endmodule // sbs_phase_table

// ==== rtl/sbs_startup_seq.v ====
// Purpose: Align, ramp and run sequencing with commutation stepping.
// Assumes: Inputs synchronous to core_clk; oscillator arrives as a level.
// Notes:   Oscillator edges are detected after a two-stage synchroniser.
//          Drives trail a state change by two cycles; tighter phase
//          timing would need the table stage folded into the output flops.
`timescale 1ns/1ps
`include "sbs_map.vh"
module sbs_startup_seq (
  input  wire core_clk,              // System clock, 50 MHz.
  input  wire sys_rst,               // Asynchronous reset, active high.
  input  wire clk_en,                // Freezes all state while low.
  input  wire osc_in,                // Oscillator output level.
  input  wire align_timing_cap,      // Align comparator tripped, high.
  input  wire ramp_timing_cap,       // Ramp comparator tripped, high.
  input  wire dir_fwd,               // High forward, low reverse.
  input  wire phase_sense_a,         // Phase A sense level.
  input  wire phase_sense_b,         // Phase B sense level.
  input  wire phase_sense_c,         // Phase C sense level.
  output reg  low_drive_a,           // Low drive a, active high.
  output reg  low_drive_b,           // Low drive b, active high.
  output reg  low_drive_c,           // Low drive c, active high.
  output reg  high_drive_a_n,        // High drive a, active low.
  output reg  high_drive_b_n,        // High drive b, active low.
  output reg  high_drive_c_n,        // High drive c, active low.
  output reg  sampler_en,            // Back-EMF sampler enable.
  output reg  ramp_src_en,           // Ramp current source enable.
  output reg  sampled_phase,         // Selected phase sense level.
  output reg  [1:0] sample_sel,      // Selected phase code.
  output reg  [1:0] mode,            // Current mode code.
  output reg  commutation_clock_out  // Tachometer output.
);
  reg [`SBS_SYNC_W-1:0] osc_sync_reg;
  reg        osc_prev_reg;
  reg [1:0]  mode_reg;
  reg [1:0]  mode_next;
  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  wire       osc_rise;
  wire [2:0] lo_w;
  wire [2:0] hi_w;
  wire [1:0] sel_w;

  // Mode codes as seen by the sequencing logic.
  localparam [1:0] MODE_ALIGN = `SBS_MODE_ALIGN;
  localparam [1:0] MODE_RAMP  = `SBS_MODE_RAMP;
  localparam [1:0] MODE_RUN   = `SBS_MODE_RUN;

  // Commutation states that the sequencer names directly; the others are
  // reached only by stepping.
  localparam [2:0] ST_RESET = `SBS_ST_R;
  localparam [2:0] ST_FIRST = `SBS_ST_A;
  localparam [2:0] ST_LAST  = `SBS_ST_F;

  // Pick the sense level named by a select code; no select gives a low.
  // The code given must match the drives now at the pins, otherwise a
  // driven rail would be read in place of the floating phase.
  function sbs_pick;
    input [1:0] sel;
    input       pa;
    input       pb;
    input       pc;
    begin
      case (sel)
        `SBS_SEL_A: sbs_pick = pa;
        `SBS_SEL_B: sbs_pick = pb;
        `SBS_SEL_C: sbs_pick = pc;
        default:    sbs_pick = 1'b0;
      endcase
    end
  endfunction

  // Next state in the chosen direction; reverse walks A from F backward.
  function [2:0] sbs_step;
    input [2:0] st;
    input       fwd;
    begin
      if (fwd)
        sbs_step = (st == `SBS_ST_F || st == `SBS_ST_R) ?
                   `SBS_ST_A : st + 3'h1;
      else
        sbs_step = (st == `SBS_ST_A || st == `SBS_ST_R) ?
                   `SBS_ST_F : st - 3'h1;
    end
  endfunction

  // Two flops align the oscillator; only the second is watched for edges.
  // The synchroniser limits the oscillator to at least one core cycle per
  // half period; faster edges would be merged and steps lost.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_sync_reg <= {`SBS_SYNC_W{1'b0}};
      osc_prev_reg <= 1'b0;
    end else if (clk_en) begin
      osc_sync_reg <= {osc_sync_reg[0], osc_in};
      osc_prev_reg <= osc_sync_reg[`SBS_SYNC_W-1];
    end
  end
  assign osc_rise = osc_sync_reg[`SBS_SYNC_W-1] & ~osc_prev_reg;

  // Mode and commutation state decisions.
  // An align trip in the same cycle as an oscillator edge wins and that
  // edge is not stepped, so the ramp opens on ST_FIRST forward and on ST_LAST in reverse.
  always @* begin
    mode_next  = mode_reg;
    state_next = state_reg;
    case (mode_reg)
      MODE_ALIGN: begin
        state_next = ST_RESET;
        if (align_timing_cap) begin
          mode_next  = MODE_RAMP;
          state_next = dir_fwd ? ST_FIRST : ST_LAST;
        end
      end
      MODE_RAMP: begin
        if (osc_rise) begin
          state_next = sbs_step(state_reg, dir_fwd);
        end
        if (ramp_timing_cap) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_RUN: begin
        // Comparator inputs are ignored here; only reset leaves run.
        if (osc_rise) begin
          state_next = sbs_step(state_reg, dir_fwd);
        end
      end
      default: begin
        mode_next  = MODE_ALIGN;
        state_next = ST_RESET;
      end
    endcase
  end

  // Mode and state registers; reset always returns to align.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg  <= `SBS_MODE_ALIGN;
      state_reg <= `SBS_ST_R;
    end else if (clk_en) begin
      mode_reg  <= mode_next;
      state_reg <= state_next;
    end
  end

  sbs_phase_table u_table (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .state    (state_reg),
    .low_drv  (lo_w),
    .high_n   (hi_w),
    .sel      (sel_w)
  );

  // Drive and select flops: one cycle behind the table, so the pins and
  // the select code always change together.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_drive_a    <= 1'b0;
      low_drive_b    <= 1'b1;
      low_drive_c    <= 1'b0;
      high_drive_a_n <= 1'b0;
      high_drive_b_n <= 1'b1;
      high_drive_c_n <= 1'b0;
      sample_sel     <= `SBS_SEL_NONE;
    end else if (clk_en) begin
      {low_drive_c, low_drive_b, low_drive_a} <= lo_w;
      {high_drive_c_n, high_drive_b_n, high_drive_a_n} <= hi_w;
      sample_sel  <= sel_w;
    end
  end

  // Sampled level, taken with the select that is already at the pins, so
  // a phase is read only while the bridge leaves it floating. It trails
  // the drives by one cycle, which is cheaper than reading a driven rail.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampled_phase <= 1'b0;
    end else if (clk_en) begin
      sampled_phase <= sbs_pick(sample_sel, phase_sense_a,
                                phase_sense_b, phase_sense_c);
    end
  end

  // Mode, enables and tachometer flops.
  // The enables follow mode_reg in the same stage as the mode output, so
  // all three change on one edge.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampler_en     <= 1'b0;
      ramp_src_en    <= 1'b0;
      mode           <= MODE_ALIGN;
      commutation_clock_out <= 1'b0;
    end else if (clk_en) begin
      sampler_en  <= (mode_reg == MODE_RUN);
      ramp_src_en <= (mode_reg == MODE_RAMP);
      mode        <= mode_reg;
      // The tachometer is the synchronised level, a fixed delay behind.
      commutation_clock_out <= osc_sync_reg[`SBS_SYNC_W-1];
    end
  end
endmodule // sbs_startup_seq

// ==== tb/sbs_bridge_model.sv ====
// Purpose: Bridge and motor stand-in that feeds the phase sense levels.
// Assumes: Drive polarities as at the sequencer outputs.
// Notes:   An undriven phase shows the back-EMF level given on bemf.
`timescale 1ns/1ps
module sbs_bridge_model (
  input  wire low_drive_a, low_drive_b, low_drive_c, // Low drives.
  input  wire high_drive_a_n, high_drive_b_n, high_drive_c_n, // High.
  input  wire bemf,                                  // Floating level.
  output wire phase_sense_a, phase_sense_b, phase_sense_c // Senses.
);
  // A driven phase sits at its rail, so only a floating one carries bemf.
  assign phase_sense_a = !high_drive_a_n ? 1'b1 : low_drive_a ? 1'b0 : bemf;
  assign phase_sense_b = !high_drive_b_n ? 1'b1 : low_drive_b ? 1'b0 : bemf;
  assign phase_sense_c = !high_drive_c_n ? 1'b1 : low_drive_c ? 1'b0 : bemf;
endmodule // sbs_bridge_model

// ==== tb/sbs_seq_chk.sv ====
// Purpose: Port assertions for the startup sequencer.
// Assumes: clk_en is held high by the bench.
// Notes:   Bound into every sequencer instance.
`timescale 1ns/1ps
module sbs_seq_chk (
  input wire core_clk, sys_rst, osc_in, align_timing_cap, ramp_timing_cap,
  input wire low_drive_a, low_drive_b, low_drive_c, high_drive_a_n,
  input wire high_drive_b_n, high_drive_c_n, sampler_en, ramp_src_en,
  input wire commutation_clock_out,
  input wire [1:0] sample_sel, mode
);
  // Phases neither pulled low nor pushed high; bit 0 is phase a.
  wire [2:0] idle = ~{low_drive_c, low_drive_b, low_drive_a}
                  & {high_drive_c_n, high_drive_b_n, high_drive_a_n};
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_align_drv; mode == 2'h0 |-> {low_drive_a, low_drive_b,
    low_drive_c, high_drive_a_n, high_drive_b_n, high_drive_c_n} == 6'h12;
  endproperty
  a_align_drv: assert property (p_align_drv)
    else $error("align drive");
  property p_align_exit; mode == 2'h0 && align_timing_cap |-> ##2 mode == 2'h1;
  endproperty
  a_align_exit: assert property (p_align_exit)
    else $error("align exit");
  property p_ramp_cause; $changed(mode) && mode == 2'h1
    |-> $past(align_timing_cap, 2); endproperty
  a_ramp_cause: assert property (p_ramp_cause)
    else $error("ramp cause");
  property p_ramp_exit; mode == 2'h1 && ramp_timing_cap |-> ##2 mode == 2'h2;
  endproperty
  a_ramp_exit: assert property (p_ramp_exit)
    else $error("ramp exit");
  property p_run_hold; mode == 2'h2 |=> mode == 2'h2; endproperty
  a_run_hold: assert property (p_run_hold) else $error("left run");
  property p_enables; {sampler_en, ramp_src_en} == {mode == 2'h2,
    mode == 2'h1}; endproperty
  a_enables: assert property (p_enables) else $error("enables");
  property p_tach; commutation_clock_out == $past(osc_in, 3); endproperty
  a_tach: assert property (p_tach) else $error("tach output");
  property p_sample_idle; sample_sel != 2'h0 |-> idle[sample_sel - 2'h1];
  endproperty
  a_sample_idle: assert property (p_sample_idle)
    else $error("sampled");
  c_ramp_step: cover property (mode == 2'h1 && $rose(osc_in));
  c_run: cover property (mode == 2'h2);
  c_run_c: cover property (mode == 2'h2 && sample_sel == 2'h3);
endmodule // sbs_seq_chk
bind sbs_startup_seq sbs_seq_chk u_chk (.core_clk, .sys_rst, .osc_in,
  .align_timing_cap, .ramp_timing_cap, .low_drive_a, .low_drive_b,
  .low_drive_c, .high_drive_a_n, .high_drive_b_n, .high_drive_c_n,
  .sampler_en, .ramp_src_en, .commutation_clock_out, .sample_sel, .mode);

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the startup sequencer.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Expected drives come from the bench's own state table.
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, osc_in = 0, bemf = 0;
  logic align_timing_cap = 0, ramp_timing_cap = 0, dir_fwd = 1;
  wire phase_sense_a, phase_sense_b, phase_sense_c, sampled_phase;
  wire low_drive_a, low_drive_b, low_drive_c, high_drive_a_n;
  wire high_drive_b_n, high_drive_c_n, sampler_en, ramp_src_en;
  wire commutation_clock_out;
  wire [1:0] sample_sel, mode;
  wire [7:0] obs = {sample_sel, low_drive_a, low_drive_b, low_drive_c,
                    high_drive_a_n, high_drive_b_n, high_drive_c_n};
  integer num_errors = 0, num_checks = 0;
  sbs_startup_seq u_dut (.core_clk, .sys_rst, .clk_en, .osc_in,
    .align_timing_cap, .ramp_timing_cap, .dir_fwd, .phase_sense_a,
    .phase_sense_b, .phase_sense_c, .low_drive_a, .low_drive_b, .low_drive_c,
    .high_drive_a_n, .high_drive_b_n, .high_drive_c_n, .sampler_en,
    .ramp_src_en, .sampled_phase, .sample_sel, .mode, .commutation_clock_out);
  sbs_bridge_model u_bridge (.low_drive_a, .low_drive_b, .low_drive_c,
    .high_drive_a_n, .high_drive_b_n, .high_drive_c_n, .bemf,
    .phase_sense_a, .phase_sense_b, .phase_sense_c);
  // Free-running 50 MHz clock.
  initial forever #10 core_clk = ~core_clk;
  // Select code then drives a,b,c low and a,b,c high for states R, A to F.
  function automatic [7:0] row(input integer s);
    case (s)
      1: row = 8'h8B; 2: row = 8'h4D; 3: row = 8'hE5;
      4: row = 8'hA6; 5: row = 8'h56; 6: row = 8'hD3;
      default: row = 8'h12;
    endcase
  endfunction
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n); repeat (n) @(posedge core_clk); #1; endtask
  task wait_mode(input [1:0] m);
    integer i;
    for (i = 0; mode !== m; i++) begin
      if (i == 20) begin num_errors++; give_verdict; end
      cyc(1);
    end
  endtask
  // One oscillator pulse, then the new state must show at the pins.
  task step(input integer s);
    osc_in = 1; cyc(1); osc_in = 0; bemf = ~bemf; cyc(2);
    chk({7'h0, commutation_clock_out}, 8'h01);
    cyc(3);
    chk(obs, row(s));
    chk({7'h0, sampled_phase}, {7'h0, bemf});
  endtask
  // Leave align by a one-cycle comparator trip and check state s.
  task start_ramp(input integer s);
    align_timing_cap = 1; cyc(1); align_timing_cap = 0;
    wait_mode(2'h1); cyc(2);
    chk(obs, row(s));
    chk({6'h0, sampler_en, ramp_src_en}, 8'h01);
  endtask
  task t_align;
    ramp_timing_cap = 1; osc_in = 1; cyc(1); osc_in = 0; cyc(8);
    chk(obs, row(0));
    chk({6'h0, mode}, 8'h00);
    ramp_timing_cap = 0;
    $display("test align done");
  endtask
  task t_forward;
    integer s;
    start_ramp(1);
    for (s = 2; s <= 8; s++) step((s - 1) % 6 + 1);
    ramp_timing_cap = 1; cyc(1); ramp_timing_cap = 0; wait_mode(2'h2);
    chk({6'h0, sampler_en, ramp_src_en}, 8'h02);
    step(3); step(4);
    align_timing_cap = 1; ramp_timing_cap = 1; cyc(6);
    chk({6'h0, mode}, 8'h02);
    align_timing_cap = 0; ramp_timing_cap = 0;
    $display("test forward done");
  endtask
  task t_reverse;
    integer s;
    sys_rst = 1; dir_fwd = 0; cyc(3); sys_rst = 0;
    cyc(2); chk(obs, row(0));
    start_ramp(6);
    for (s = 11; s >= 6; s--) step((s - 1) % 6 + 1);
    $display("test reverse done");
  endtask
  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    cyc(3); sys_rst = 0;
    t_align;
    t_forward;
    t_reverse;
    give_verdict;
  end
endmodule // testbench
